// File: crf_receive.sv
`timescale 1ns/100ps
module crf_receive (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_valid,
	input wire logic [crf_pkg::ID_W-1:0] frame_id,
	input wire logic frame_extended_id_bit,
	input wire logic [63:0] frame_data,
	input wire logic rx_error,
	input wire logic wake_event,
	output logic irq
);
	import crf_pkg::*;

	// =====================================
	// state
	logic [31:0] filt_q [NFILT];
	logic [ID_W-1:0] msk_q [2];
	logic [ID_W:0] bid_q [2];
	logic [63:0] bdat_q [2];
	logic [1:0] buffer_full_flag_q;
	logic double_buffer_enable_q;
	logic [S_W-1:0] stat_q;
	logic [S_W-1:0] mask_q;
	logic [7:0] rec_q;
	logic [ID_W:0] mab_id_q;
	logic [63:0] mab_dat_q;
	logic mab_v_q;

	// =====================================
	// bus decode
	logic wr;
	logic rd_ok;
	logic [31:0] rd_d;
	logic [2:0] fidx;
	assign wr = psel && penable && pwrite;
	assign fidx = 3'((paddr - A_FILT) >> 2);
	logic filt_sel;
	assign filt_sel = paddr >= A_FILT && paddr < A_B0ID && paddr[1:0] == 2'b00;

	always_comb begin
		rd_ok = 1'b1;
		rd_d = '0;
		if (paddr == A_CTRL) begin
			rd_d[C_DOUBLE_BUFFER_ENABLE] = double_buffer_enable_q;
			rd_d[C_FUL0] = buffer_full_flag_q[0];
			rd_d[C_FUL1] = buffer_full_flag_q[1];
		end else if (paddr == A_STAT) begin
			rd_d[S_W-1:0] = stat_q;
		end else if (paddr == A_MASK) begin
			rd_d[S_W-1:0] = mask_q;
		end else if (paddr == A_ERRC) begin
			rd_d[7:0] = rec_q;
		end else if (paddr == A_MSK0) begin
			rd_d[ID_W-1:0] = msk_q[0];
		end else if (paddr == A_MSK1) begin
			rd_d[ID_W-1:0] = msk_q[1];
		end else if (filt_sel) begin
			rd_d = filt_q[fidx];
		end else if (paddr == A_B0ID) begin
			rd_d[ID_W:0] = bid_q[0];
		end else if (paddr == A_B0DL) begin
			rd_d = bdat_q[0][31:0];
		end else if (paddr == A_B0DH) begin
			rd_d = bdat_q[0][63:32];
		end else if (paddr == A_B1ID) begin
			rd_d[ID_W:0] = bid_q[1];
		end else if (paddr == A_B1DL) begin
			rd_d = bdat_q[1][31:0];
		end else if (paddr == A_B1DH) begin
			rd_d = bdat_q[1][63:32];
		end else begin
			rd_ok = 1'b0;
		end
	end

	// zero-wait APB: ready in every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// refused only for an unmapped word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !rd_ok;
		end
	end

	// read data stands only in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else begin
			prdata <= (psel && !penable && !pwrite) ? rd_d : '0;
		end
	end
	logic acc;
	assign acc = wr && pready;

	// write strobes, one per control register, one shared by the six filters
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic wr_errc;
	logic wr_msk0;
	logic wr_msk1;
	logic wr_filt;
	assign wr_ctrl = acc && paddr == A_CTRL;
	assign wr_stat = acc && paddr == A_STAT;
	assign wr_mask = acc && paddr == A_MASK;
	assign wr_errc = acc && paddr == A_ERRC;
	assign wr_msk0 = acc && paddr == A_MSK0;
	assign wr_msk1 = acc && paddr == A_MSK1;
	assign wr_filt = acc && filt_sel;

	// =====================================
	// configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			double_buffer_enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			double_buffer_enable_q <= pwdata[C_DOUBLE_BUFFER_ENABLE];
		end
	end

	// unimplemented bits never enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= '0;
		end else if (wr_mask) begin
			mask_q <= pwdata[S_W-1:0] & S_IMPL;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msk_q[0] <= '0;
			msk_q[1] <= '0;
		end else if (wr_msk0) begin
			msk_q[0] <= pwdata[ID_W-1:0];
		end else if (wr_msk1) begin
			msk_q[1] <= pwdata[ID_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NFILT; i++) filt_q[i] <= '0;
		end else if (wr_filt) begin
			filt_q[fidx] <= pwdata;
		end
	end

	// =====================================
	// assembly buffer, hidden from software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mab_v_q <= 1'b0;
			mab_id_q <= '0;
			mab_dat_q <= '0;
		end else begin
			mab_v_q <= frame_valid;
			if (frame_valid) begin
				mab_id_q <= {frame_extended_id_bit, frame_id};
				mab_dat_q <= frame_data;
			end
		end
	end

	// =====================================
	// acceptance filtering
	logic [NFILT-1:0] hit;
	logic to0;
	logic to1;
	// filters zero and one share mask zero
	crf_filt_match #(
		.W(ID_W)
	) i_filt0 (
		.filt_id(filt_q[0][ID_W-1:0]),
		.filt_ext(filt_q[0][F_EXT]),
		.mask(msk_q[0]),
		.frame_id(mab_id_q[ID_W-1:0]),
		.frame_ext(mab_id_q[ID_W]),
		.hit(hit[0])
	);

	crf_filt_match #(
		.W(ID_W)
	) i_filt1 (
		.filt_id(filt_q[1][ID_W-1:0]),
		.filt_ext(filt_q[1][F_EXT]),
		.mask(msk_q[0]),
		.frame_id(mab_id_q[ID_W-1:0]),
		.frame_ext(mab_id_q[ID_W]),
		.hit(hit[1])
	);

	// filters two to five share mask one
	crf_filt_match #(
		.W(ID_W)
	) i_filt2 (
		.filt_id(filt_q[2][ID_W-1:0]),
		.filt_ext(filt_q[2][F_EXT]),
		.mask(msk_q[1]),
		.frame_id(mab_id_q[ID_W-1:0]),
		.frame_ext(mab_id_q[ID_W]),
		.hit(hit[2])
	);

	crf_filt_match #(
		.W(ID_W)
	) i_filt3 (
		.filt_id(filt_q[3][ID_W-1:0]),
		.filt_ext(filt_q[3][F_EXT]),
		.mask(msk_q[1]),
		.frame_id(mab_id_q[ID_W-1:0]),
		.frame_ext(mab_id_q[ID_W]),
		.hit(hit[3])
	);

	crf_filt_match #(
		.W(ID_W)
	) i_filt4 (
		.filt_id(filt_q[4][ID_W-1:0]),
		.filt_ext(filt_q[4][F_EXT]),
		.mask(msk_q[1]),
		.frame_id(mab_id_q[ID_W-1:0]),
		.frame_ext(mab_id_q[ID_W]),
		.hit(hit[4])
	);

	crf_filt_match #(
		.W(ID_W)
	) i_filt5 (
		.filt_id(filt_q[5][ID_W-1:0]),
		.filt_ext(filt_q[5][F_EXT]),
		.mask(msk_q[1]),
		.frame_id(mab_id_q[ID_W-1:0]),
		.frame_ext(mab_id_q[ID_W]),
		.hit(hit[5])
	);
	assign to0 = mab_v_q && |hit[1:0];
	assign to1 = mab_v_q && !to0 && |hit[NFILT-1:2];

	// buffer selection and overrun
	logic ld0;
	logic ld1;
	logic ovr0;
	logic ovr1;
	always_comb begin
		ld0 = 1'b0;
		ld1 = 1'b0;
		ovr0 = 1'b0;
		ovr1 = 1'b0;
		if (to0) begin
			if (!buffer_full_flag_q[0]) begin
				ld0 = 1'b1;
			end else if (!double_buffer_enable_q) begin
				ovr0 = 1'b1;
			end else if (!buffer_full_flag_q[1]) begin
				ld1 = 1'b1;
			end else begin
				ovr1 = 1'b1;
			end
		end else if (to1) begin
			if (!buffer_full_flag_q[1]) ld1 = 1'b1;
			else ovr1 = 1'b1;
		end
	end

	// visible buffer contents
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bid_q[0] <= '0;
			bid_q[1] <= '0;
			bdat_q[0] <= '0;
			bdat_q[1] <= '0;
		end else begin
			if (ld0) begin
				bid_q[0] <= mab_id_q;
				bdat_q[0] <= mab_dat_q;
			end
			if (ld1) begin
				bid_q[1] <= mab_id_q;
				bdat_q[1] <= mab_dat_q;
			end
		end
	end

	// full flags: load wins over a software release
	logic rel0;
	logic rel1;
	assign rel0 = wr_ctrl && pwdata[C_FUL0];
	assign rel1 = wr_ctrl && pwdata[C_FUL1];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_full_flag_q <= '0;
		end else begin
			buffer_full_flag_q[0] <= ld0 || (buffer_full_flag_q[0] && !rel0);
			buffer_full_flag_q[1] <= ld1 || (buffer_full_flag_q[1] && !rel1);
		end
	end

	// =====================================
	// receive error counter
	logic warn_hit;
	// warning only when the count really steps onto the limit
	assign warn_hit = rx_error && !wr_errc && (rec_q == WARN_LIMIT - 8'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_q <= '0;
		end else if (wr_errc) begin
			rec_q <= pwdata[7:0];
		end else if (rx_error && rec_q != 8'hFF) begin
			rec_q <= rec_q + 8'h01;
		end
	end

	// =====================================
	// sticky status, write one to clear; set wins
	logic [S_W-1:0] ev;
	logic [S_W-1:0] clr;
	assign clr = wr_stat ? pwdata[S_W-1:0] : '0;
	always_comb begin
		ev = '0;
		ev[S_RX0] = ld0;
		ev[S_RX1] = ld1;
		ev[S_WAKE] = wake_event;
		ev[S_OVR0] = ovr0;
		ev[S_OVR1] = ovr1;
		ev[S_ERR] = ovr0 || ovr1;
		ev[S_WARN] = warn_hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
		end else begin
			stat_q <= ev | (stat_q & ~clr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end
endmodule

// =====================================
// one acceptance filter against the held frame
module crf_filt_match #(
	parameter int W = crf_pkg::ID_W
) (
	input wire logic [W-1:0] filt_id,
	input wire logic filt_ext,
	input wire logic [W-1:0] mask,
	input wire logic [W-1:0] frame_id,
	input wire logic frame_ext,
	output logic hit
);
	import crf_pkg::*;

	logic kind_ok;
	logic [W-1:0] diff;
	// standard frames meet standard filters only
	assign kind_ok = filt_ext == frame_ext;
	// a clear mask bit always matches
	assign diff = (filt_id ^ frame_id) & mask;
	assign hit = kind_ok && diff == '0;
endmodule

// File: crf_pkg.sv
package crf_pkg;
	localparam int ID_W = 29;
	localparam int NFILT = 6;
	localparam logic [7:0] WARN_LIMIT = 8'h60;
	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_MASK = 8'h08;
	localparam logic [7:0] A_ERRC = 8'h0C;
	localparam logic [7:0] A_MSK0 = 8'h10;
	localparam logic [7:0] A_MSK1 = 8'h14;
	localparam logic [7:0] A_FILT = 8'h18;
	localparam logic [7:0] A_B0ID = 8'h30;
	localparam logic [7:0] A_B0DL = 8'h34;
	localparam logic [7:0] A_B0DH = 8'h38;
	localparam logic [7:0] A_B1ID = 8'h3C;
	localparam logic [7:0] A_B1DL = 8'h40;
	localparam logic [7:0] A_B1DH = 8'h44;
	// status bit positions
	localparam int S_RX0 = 0;
	localparam int S_RX1 = 1;
	localparam int S_WAKE = 2;
	localparam int S_ERR = 5;
	localparam int S_WARN = 9;
	localparam int S_OVR1 = 14;
	localparam int S_OVR0 = 15;
	localparam int S_W = 16;
	localparam logic [S_W-1:0] S_IMPL = 16'hC227;
	// control bits
	localparam int C_DOUBLE_BUFFER_ENABLE = 0;
	localparam int C_FUL0 = 1;
	localparam int C_FUL1 = 2;
	// filter register: bit 31 extended select, bits 28:0 identifier
	localparam int F_EXT = 31;
endpackage

// File: crf_receive_asserts.sv
`timescale 1ns/100ps
module crf_receive_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic frame_valid,
	input wire logic rx_error,
	input wire logic wake_event
);
	import crf_pkg::*;
	// ====================
	// bus and irq checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> s_access)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_data_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero when idle");
	a_err_unmapped: assert property (pready && paddr > A_B1DH |-> pslverr)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (pready && paddr <= A_B1DH && paddr[1:0] == 2'b00
		|-> !pslverr)
		else $error("mapped access refused");
	a_irq_rise_cause: assert property ($rose(irq) |-> $past(frame_valid, 3) ||
		$past(rx_error || wake_event, 2) || $past(psel && penable && pwrite, 2))
		else $error("irq rose without a cause");
	a_irq_fall_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2))
		else $error("irq dropped without a write");
endmodule

// File: crf_engine.sv
`timescale 1ns/100ps
module crf_engine (
	input wire logic pclk,
	output logic frame_valid,
	output logic [crf_pkg::ID_W-1:0] frame_id,
	output logic frame_extended_id_bit,
	output logic [63:0] frame_data,
	output logic rx_error,
	output logic wake_event
);
	import crf_pkg::*;
	// ====================
	// protocol engine model
	initial begin
		frame_valid = 1'b0;
		frame_id = '0;
		frame_extended_id_bit = 1'b0;
		frame_data = '0;
		rx_error = 1'b0;
		wake_event = 1'b0;
	end
	// one pulse per error-free frame after end of frame
	task automatic send(input logic ext, input logic [ID_W-1:0] id);
		@(posedge pclk);
		frame_valid <= 1'b1;
		frame_id <= id;
		frame_extended_id_bit <= ext;
		frame_data <= {2{3'h5, id}};
		@(posedge pclk);
		frame_valid <= 1'b0;
		frame_id <= ~id;
		frame_data <= ~{2{3'h5, id}};
		repeat (3) @(posedge pclk);
	endtask
	// one pulse per receive error or wake event
	task automatic strobe(input logic wake);
		@(posedge pclk);
		if (wake) wake_event <= 1'b1;
		else rx_error <= 1'b1;
		@(posedge pclk);
		wake_event <= 1'b0;
		rx_error <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
endmodule

// File: crf_receive_tb.sv
`timescale 1ns/100ps
module crf_receive_tb;
	import crf_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err_q;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic pready, pslverr, irq, frame_valid, frame_extended_id_bit, rx_error, wake_event;
	logic [ID_W-1:0] frame_id;
	logic [63:0] frame_data;
	int miscompares = 0, num_checks = 0;
	always #2 pclk = ~pclk;
	crf_receive i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .frame_valid, .frame_id, .frame_extended_id_bit, .frame_data,
		.rx_error, .wake_event, .irq);
	crf_engine i_eng (.pclk, .frame_valid, .frame_id, .frame_extended_id_bit, .frame_data,
		.rx_error, .wake_event);
	// ====================
	// tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, rd_q, e);
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ====================
	// tests
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd("status", A_STAT, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		chk("unmapped", {31'h0, err_q}, 32'h1);
		apb(1'b1, A_MASK, 32'h0000C227);
		apb(1'b1, A_MSK0, 32'h1FFFFFFF);
		apb(1'b1, A_MSK1, 32'h1FFFFF00);
		apb(1'b1, A_FILT, 32'h00000123);
		apb(1'b1, A_FILT + 8'h08, 32'h81ABCDE0);
		i_eng.send(1'b0, 29'h123);
		rd("b0 id", A_B0ID, 32'h00000123);
		rd("b0 lo", A_B0DL, {3'h5, 29'h123});
		chk("irq", {31'h0, irq}, 32'h1);
		i_eng.send(1'b1, 29'h123);
		rd("status", A_STAT, 32'h1);
		i_eng.send(1'b1, 29'h1ABCDFF);
		rd("b1 id", A_B1ID, 32'h21ABCDFF);
		i_eng.send(1'b0, 29'h123);
		rd("status", A_STAT, 32'h8023);
		$display("test filters done");
		apb(1'b1, A_STAT, 32'h0000FFFF);
		apb(1'b1, A_CTRL, 32'h5);
		chk("irq clr", {31'h0, irq}, 32'h0);
		i_eng.send(1'b0, 29'h123);
		rd("b1 id", A_B1ID, 32'h00000123);
		rd("status", A_STAT, 32'h2);
		i_eng.send(1'b0, 29'h123);
		rd("status", A_STAT, 32'h4022);
		apb(1'b1, A_CTRL, 32'h6);
		rd("ctrl", A_CTRL, 32'h0);
		$display("test buffering done");
		apb(1'b1, A_ERRC, 32'h5E);
		i_eng.strobe(1'b0);
		rd("status", A_STAT, 32'h4022);
		i_eng.strobe(1'b0);
		rd("errc", A_ERRC, 32'h60);
		rd("status", A_STAT, 32'h4222);
		i_eng.strobe(1'b1);
		rd("status", A_STAT, 32'h4226);
		apb(1'b1, A_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, A_MASK, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq wake", {31'h0, irq}, 32'h1);
		$display("test errors done");
		results;
	end
	initial begin
		repeat (2000) @(posedge pclk);
		miscompares++;
		results;
	end
endmodule
bind crf_receive crf_receive_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .irq, .frame_valid, .rx_error, .wake_event);
